// *** include/gbps_consts.vh ***
// Constants for the status/control bit pointer of the first general pin
`ifndef GBPS_CONSTS_VH
`define GBPS_CONSTS_VH

// --------------------------------------------------------------
// Register map
// --------------------------------------------------------------
`define GBPS_ADDR_W 16
`define GBPS_PTR_ADDR_HI 16'h00E0
`define GBPS_PTR_ADDR_LO 16'h00E1
`define GBPS_PTR_RESET 16'h0000
`define GBPS_RDATA_UNMAPPED 8'h00
`define GBPS_PTR_W 16
`define GBPS_DATA_W 8
// High byte of the pointer sits at the lower address
`define GBPS_HI_MSB 15
`define GBPS_HI_LSB 8
`define GBPS_LO_MSB 7
`define GBPS_LO_LSB 0

// --------------------------------------------------------------
// Pointer field layout
// --------------------------------------------------------------
`define GBPS_BIT_MSB 14
`define GBPS_BIT_LSB 12
`define GBPS_PAGE_MSB 11
`define GBPS_PAGE_LSB 8
`define GBPS_OFS_MSB 6
`define GBPS_OFS_LSB 0
`define GBPS_BIT_W 3
`define GBPS_PAGE_W 4
`define GBPS_OFS_W 7
// Writable bits; 15 and 7 are reserved
`define GBPS_PTR_WMASK 16'h7F7F

// --------------------------------------------------------------
// Map geometry
// --------------------------------------------------------------
`define GBPS_PAGE_BYTES 128
`define GBPS_MAP_ADDR_W 11

`endif

// *** verilog/gbps_ptr_decode.v ***
// Pointer field split, map address forming and bit pick
`timescale 1ns/10ps
`default_nettype none
`include "gbps_consts.vh"

module gbps_ptr_decode (
	input wire [`GBPS_PTR_W-1:0] ptr_i,
	input wire [`GBPS_DATA_W-1:0] map_byte_i,
	output wire [`GBPS_BIT_W-1:0] bit_sel_o,
	output wire [`GBPS_PAGE_W-1:0] page_o,
	output wire [`GBPS_OFS_W-1:0] offset_o,
	output wire [`GBPS_MAP_ADDR_W-1:0] map_addr_o,
	output wire map_bit_o
);

	assign bit_sel_o = ptr_i[`GBPS_BIT_MSB:`GBPS_BIT_LSB];
	assign page_o = ptr_i[`GBPS_PAGE_MSB:`GBPS_PAGE_LSB];
	assign offset_o = ptr_i[`GBPS_OFS_MSB:`GBPS_OFS_LSB];
	// 128-byte pages, so page and offset simply concatenate; 16 pages fill the map
	assign map_addr_o = {page_o, offset_o};
	assign map_bit_o = map_byte_i[bit_sel_o];

endmodule
`default_nettype wire

// *** verilog/gbps_top.v ***
// Bit pointer register tying the first general pin to one host map bit
`timescale 1ns/10ps
`default_nettype none
`include "gbps_consts.vh"

// Summary of operation
// - Pointer fields act only while first general pin is in status/control mode.
// - Pointer bits 14:12 pick the bit within the addressed byte.
// - Pointer bits 11:8 give the register page number.
// - Pointer bits 6:0 give the byte offset inside the page.
// - Pages hold 128 bytes; pages 0 to 15 cover the whole map.
module gbps_top (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire [`GBPS_ADDR_W-1:0] reg_addr_i,
	input wire reg_wr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_rd_i,
	input wire sc_mode_i,
	input wire [7:0] map_byte_i,
	output reg [7:0] reg_rdata_o,
	output reg ptr_active_o,
	output reg [`GBPS_BIT_W-1:0] bit_sel_o,
	output reg [`GBPS_MAP_ADDR_W-1:0] map_addr_o,
	output reg first_general_pin_bit_o
);

	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	// Assertion acts at once; release waits two edges so that no flop
	// leaves reset on an edge that falls close to the rising pin
	reg rst_meta_r;
	reg rst_sync_r;
	wire rstn;

	always @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	assign rstn = rst_sync_r;

	// --------------------------------------------------------------
	// Host access decode
	// --------------------------------------------------------------
	// Two byte addresses belong to this block; paging is resolved
	// upstream, so the address arrives linear
	wire hit_hi;
	wire hit_lo;
	wire wr_hi;
	wire wr_lo;

	assign hit_hi = (reg_addr_i == `GBPS_PTR_ADDR_HI);
	assign hit_lo = (reg_addr_i == `GBPS_PTR_ADDR_LO);

	assign wr_hi = reg_wr_i && hit_hi;
	assign wr_lo = reg_wr_i && hit_lo;

	// --------------------------------------------------------------
	// Pointer register
	// --------------------------------------------------------------
	// Lane 1 is the high byte, lane 0 the low byte
	localparam N_LANES = `GBPS_PTR_W / `GBPS_DATA_W;

	reg [`GBPS_PTR_W-1:0] status_control_bit_pointer_r;
	wire [`GBPS_PTR_W-1:0] ptr_nxt;
	wire [`GBPS_PTR_W-1:0] ptr_wmask;
	wire [N_LANES-1:0] lane_wr;

	assign ptr_wmask = `GBPS_PTR_WMASK;
	assign lane_wr = {wr_hi, wr_lo};

	// Each byte lands on its own, with no atomic pair: a host moving
	// page and offset may point at a mixed location for a cycle
	genvar lane;
	generate
		for (lane = 0; lane < N_LANES; lane = lane + 1) begin : g_lane
			wire [`GBPS_DATA_W-1:0] cur_byte;
			wire [`GBPS_DATA_W-1:0] new_byte;
			wire [`GBPS_DATA_W-1:0] keep_mask;

			assign cur_byte = status_control_bit_pointer_r[lane*`GBPS_DATA_W +: `GBPS_DATA_W];
			assign keep_mask = ptr_wmask[lane*`GBPS_DATA_W +: `GBPS_DATA_W];
			assign new_byte = lane_wr[lane] ? reg_wdata_i : cur_byte;
			// Reserved bits never store a one, so they read back as zero
			assign ptr_nxt[lane*`GBPS_DATA_W +: `GBPS_DATA_W] = new_byte & keep_mask;
		end
	endgenerate

	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			status_control_bit_pointer_r <= `GBPS_PTR_RESET;
		end else begin
			status_control_bit_pointer_r <= ptr_nxt;
		end
	end

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	reg [`GBPS_DATA_W-1:0] rdata_nxt;

	always @* begin
		case (reg_addr_i)
			`GBPS_PTR_ADDR_HI: begin
				rdata_nxt = status_control_bit_pointer_r[`GBPS_HI_MSB:`GBPS_HI_LSB];
			end
			`GBPS_PTR_ADDR_LO: begin
				rdata_nxt = status_control_bit_pointer_r[`GBPS_LO_MSB:`GBPS_LO_LSB];
			end
			// Foreign addresses read as zero; no error is flagged
			default: begin
				rdata_nxt = `GBPS_RDATA_UNMAPPED;
			end
		endcase
	end

	// Read data holds until the next read strobe; a read in a write
	// cycle returns the byte as it was before that write
	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_o <= `GBPS_RDATA_UNMAPPED;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rdata_nxt;
		end
	end

	// --------------------------------------------------------------
	// Pointer decode
	// --------------------------------------------------------------
	wire [`GBPS_BIT_W-1:0] dec_bit;
	wire [`GBPS_MAP_ADDR_W-1:0] dec_addr;
	wire dec_map_bit;

	// Page and offset already travel inside the map address
	gbps_ptr_decode u_decode (
		.ptr_i(status_control_bit_pointer_r),
		.map_byte_i(map_byte_i),
		.bit_sel_o(dec_bit),
		.page_o(),
		.offset_o(),
		.map_addr_o(dec_addr),
		.map_bit_o(dec_map_bit)
	);

	// --------------------------------------------------------------
	// Pin mode gate
	// --------------------------------------------------------------
	// Mode comes from pin configuration logic on this clock, so no
	// synchroniser; outside status/control every pointer output sits at zero
	reg ptr_active_nxt;
	reg [`GBPS_BIT_W-1:0] bit_sel_nxt;
	reg [`GBPS_MAP_ADDR_W-1:0] map_addr_nxt;
	reg pin_bit_nxt;

	always @* begin
		ptr_active_nxt = 1'b0;
		bit_sel_nxt = {`GBPS_BIT_W{1'b0}};
		map_addr_nxt = {`GBPS_MAP_ADDR_W{1'b0}};
		pin_bit_nxt = 1'b0;

		if (sc_mode_i) begin
			ptr_active_nxt = 1'b1;
			bit_sel_nxt = dec_bit;
			map_addr_nxt = dec_addr;
			pin_bit_nxt = dec_map_bit;
		end
	end

	// --------------------------------------------------------------
	// Output registers
	// --------------------------------------------------------------
	// The picked bit trails a pointer change by two cycles, one more than map_addr_o, because the
	// map byte answers the address shown at the previous edge
	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			ptr_active_o <= 1'b0;
		end else begin
			ptr_active_o <= ptr_active_nxt;
		end
	end

	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			bit_sel_o <= {`GBPS_BIT_W{1'b0}};
		end else begin
			bit_sel_o <= bit_sel_nxt;
		end
	end

	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			map_addr_o <= {`GBPS_MAP_ADDR_W{1'b0}};
		end else begin
			map_addr_o <= map_addr_nxt;
		end
	end

	always @(posedge clk_sys_i or negedge rstn) begin
		if (!rstn) begin
			first_general_pin_bit_o <= 1'b0;
		end else begin
			first_general_pin_bit_o <= pin_bit_nxt;
		end
	end

endmodule
`default_nettype wire

// *** sim/gbps_top_properties.sv ***
// Checker for the bit pointer register and pointer outputs
`timescale 1ns/10ps
`default_nettype none
module gbps_top_properties (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic sc_mode_i,
	input wire logic ptr_active_o,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic [7:0] map_byte_i,
	input wire logic [2:0] bit_sel_o,
	input wire logic [10:0] map_addr_o,
	input wire logic first_general_pin_bit_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	wire logic hi_w = reg_wr_i && reg_addr_i == 16'h00E0;
	wire logic lo_w = reg_wr_i && reg_addr_i == 16'h00E1;
	wire logic ptr_rd = reg_rd_i && (reg_addr_i == 16'h00E0 || reg_addr_i == 16'h00E1);
	chk_mode_gates: assert property (!sc_mode_i |=> !ptr_active_o && bit_sel_o == 3'h0 &&
		map_addr_o == 11'h000 && !first_general_pin_bit_o) else $error("outputs not idle");
	chk_bit_field: assert property ($past(sc_mode_i) && $past(hi_w, 2) |->
		bit_sel_o == $past(reg_wdata_i[6:4], 2)) else $error("bit index wrong");
	chk_page_field: assert property ($past(sc_mode_i) && $past(hi_w, 2) |->
		map_addr_o[10:7] == $past(reg_wdata_i[3:0], 2)) else $error("page wrong");
	chk_offset_field: assert property ($past(sc_mode_i) && $past(lo_w, 2) |->
		map_addr_o[6:0] == $past(reg_wdata_i[6:0], 2)) else $error("offset wrong");
	chk_bit_pick: assert property ($past(ptr_active_o) && ptr_active_o && $stable(bit_sel_o) |->
		first_general_pin_bit_o == $past(map_byte_i[bit_sel_o])) else $error("pin bit wrong");
	chk_rsvd_read: assert property (ptr_rd |=> !reg_rdata_o[7]) else $error("bit 7 set");
	cover property (hi_w ##2 ptr_active_o);
	cover property ($fell(sc_mode_i));
	cover property (ptr_rd && reg_addr_i == 16'h00E1);
endmodule
bind gbps_top gbps_top_properties u_chk (
	.clk_sys_i(clk_sys_i),
	.resetn_i(resetn_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.sc_mode_i(sc_mode_i),
	.ptr_active_o(ptr_active_o),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o),
	.map_byte_i(map_byte_i),
	.bit_sel_o(bit_sel_o),
	.map_addr_o(map_addr_o),
	.first_general_pin_bit_o(first_general_pin_bit_o)
);
`default_nettype wire

// *** sim/gbps_map_model.sv ***
// Host register map model supplying the addressed byte
`timescale 1ns/10ps
`default_nettype none
module gbps_map_model (
	input wire logic [10:0] map_addr_i,
	output logic [7:0] map_byte_o
);
	// Fixed pattern of the address, so each pick is predictable
	assign map_byte_o = map_addr_i[10:3] ^ map_addr_i[7:0];
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Bench for the bit pointer block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_sys_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0, sc_mode_i = 0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [7:0] reg_wdata_i = 8'h00;
	wire logic [7:0] reg_rdata_o, map_byte_i;
	wire logic [2:0] bit_sel_o;
	wire logic [10:0] map_addr_o;
	wire logic ptr_active_o, first_general_pin_bit_o;
	int n_fail = 0, compares = 0;
	logic [15:0] tbl [4] = '{16'h3205, 16'h7F7F, 16'h0F00, 16'h4A11};
	gbps_top dut (
		.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i),
		.reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_rd_i(reg_rd_i),
		.sc_mode_i(sc_mode_i),
		.map_byte_i(map_byte_i),
		.reg_rdata_o(reg_rdata_o),
		.ptr_active_o(ptr_active_o),
		.bit_sel_o(bit_sel_o),
		.map_addr_o(map_addr_o),
		.first_general_pin_bit_o(first_general_pin_bit_o)
	);
	gbps_map_model map (.map_addr_i(map_addr_o), .map_byte_o(map_byte_i));
	initial forever #50 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w);
		@(negedge clk_sys_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = w;
		reg_rd_i = !w;
		@(negedge clk_sys_i);
		reg_wr_i = 0;
		reg_rd_i = 0;
	endtask
	task automatic t_regs;
		acc(16'h00E0, 8'h00, 0);
		chk(reg_rdata_o, 16'h0000);
		acc(16'h00E0, 8'hFF, 1);
		acc(16'h00E1, 8'hFF, 1);
		acc(16'h00E0, 8'h00, 0);
		chk(reg_rdata_o, 16'h007F);
		acc(16'h00E1, 8'h00, 0);
		chk(reg_rdata_o, 16'h007F);
		acc(16'h00E2, 8'h00, 0);
		chk(reg_rdata_o, 16'h0000);
	endtask
	task automatic t_fields;
		logic [15:0] p;
		logic [10:0] a;
		sc_mode_i = 1;
		for (int i = 0; i < 4; i++) begin
			p = tbl[i];
			acc(16'h00E0, p[15:8], 1);
			acc(16'h00E1, p[7:0], 1);
			@(negedge clk_sys_i);
			a = 11'(p[11:8] * 128 + p[6:0]);
			chk(bit_sel_o, p[14:12]);
			chk(map_addr_o, a);
			@(negedge clk_sys_i);
			chk(first_general_pin_bit_o, (a[10:3] ^ a[7:0]) >> p[14:12] & 1);
		end
	endtask
	task automatic t_mode;
		sc_mode_i = 0;
		acc(16'h00E0, 8'h35, 1);
		chk(ptr_active_o, 0);
		chk(map_addr_o, 0);
		chk(bit_sel_o, 0);
		chk(first_general_pin_bit_o, 0);
		sc_mode_i = 1;
		@(negedge clk_sys_i);
		chk(ptr_active_o, 1);
		chk(map_addr_o, 11'h291);
	endtask
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		stop_test;
	end
	initial begin
		repeat (4) @(negedge clk_sys_i);
		resetn_i = 1;
		repeat (3) @(negedge clk_sys_i);
		t_regs;
		t_fields;
		t_mode;
		stop_test;
	end
endmodule
`default_nettype wire
